// >>> rtl/wake_defs.svh
`ifndef WAKE_DEFS_SVH
`define WAKE_DEFS_SVH
`define MASK_GENERAL_WAKEUP_BIT_POS   4
`define MASK_WAKEUP_MASK_BIT_POS    14
`define MASK_READY_POS   1
`define MASK_BVD_LO_POS  2
`define MASK_BVD_HI_POS  3
`define MASK_WP_POS      0
`define EVT_WIDTH        16
`define EVT_RESET        16'h0000
`define PSTATE_D0        2'h0
`define PSTATE_D1        2'h1
`define PSTATE_D2        2'h2
`define PSTATE_D3        2'h3
`endif

// >>> rtl/wake_pkg.sv
package wake_pkg;
   typedef enum logic [1:0]
   {
      DEV_D0 = 2'b00,
      DEV_D1 = 2'b01,
      DEV_D2 = 2'b10,
      DEV_D3 = 2'b11
   } power_state_t;
   typedef struct packed
   {
      logic        valid;
      logic        type0;
      logic        write;
   } bus_cycle_t;
   typedef struct packed
   {
      logic        set_en;
      logic        clr_en;
      logic        clr_status;
   } pm_write_t;
endpackage

// >>> rtl/wake_sync.sv
`timescale 1ns/10ps
module wake_sync
#(
   parameter int WIDTH = 1
)
(
   input  wire logic             ref_clk,
   input  wire logic             reset_n,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] stage1;
   always_ff @(posedge ref_clk)
   begin
      if (!reset_n)
      begin
         stage1   <= '0;
         sync_out <= '0;
      end
      else
      begin
         stage1   <= async_in;
         sync_out <= stage1;
      end
   end
endmodule // wake_sync

// >>> rtl/card_wake_event_logic.sv
// Notes on behaviour
// RL1 - In hot D3 config space readable; only wake context and PM bits kept.
// RL2 - In hot D3 only type 0 configuration cycles are answered.
// RL3 - In cold D3 no bus cycle of any kind is answered.
// RL4 - Host stops clock and holds card reset and clock low in cold D3.
// RL5 - In cold D3 wake context and wake request survive only with wake enable.
// RL6 - No interrupts in cold D3 until the function is operational again.
// RL7 - Wake context is the event register plus the event mask register.
// RL8 - Writing wake enable sets or clears mask bits 4 and 14 together.
// RL9 - Clearing the mask bits leaves wake enable untouched.
// RL10 - General wakeup bit of the event register flags the wake event.
// RL11 - With wake enable, status change events set wake status and general wakeup.
// RL12 - Clearing wake enable drops the pin and clears both mask bits.
// RL13 - Writing 1 to wake status clears general wakeup, and the reverse.
// RL14 - Ready, battery and write-protect masks may raise the pin without wake status.
// RL15 - With wake enable low, event register changes leave enable and status alone.
// RL16 - Wake enable, masks, general wakeup, pin and wake status reset to 0.
// RL17 - In D1 to D3 the pin asserts only with wake enable; D0 always.
// RL18 - The pin holds until wake status or wake enable is cleared.
// RL19 - Wake status survives card reset when auxiliary power is present.
// RL20 - The pin is the OR of masked latched events, gated by power state.
`timescale 1ns/10ps
`include "wake_defs.svh"
module card_wake_event_logic
   import wake_pkg::*;
#(
   parameter int  EVT_W       = `EVT_WIDTH,
   parameter bit  AUX_POWERED = 1'b1
)
(
   input  wire logic             ref_clk,
   input  wire logic             reset_n,
   input  wire logic             aux_reset_n,
   input  wire logic             cold_sleep,
   input  wire logic             card_clock_pin,
   input  wire power_state_t     power_state,
   input  wire pm_write_t        pm_write,
   input  wire logic             mask_write,
   input  wire logic [EVT_W-1:0] mask_wdata,
   input  wire logic             event_clear,
   input  wire logic [EVT_W-1:0] event_clear_bits,
   input  wire logic [EVT_W-1:0] event_sources,
   input  wire logic             wake_source,
   input  wire bus_cycle_t       bus_cycle,
   input  wire logic             irq_request,
   output logic                  wake_enable,
   output logic                  wake_status,
   output logic [EVT_W-1:0]      event_mask,
   output logic [EVT_W-1:0]      event_reg,
   output logic                  card_status_change,
   output logic                  bus_accept,
   output logic                  irq_out,
   output logic                  card_clock_edge
);
   // ******************************************************
   // Input synchronisers
   // ******************************************************
   logic [EVT_W-1:0] src_sync;
   logic             wake_src_sync;
   logic             clk_sync;
   logic             clk_prev;
   logic             wake_src_prev;
   wake_sync #(.WIDTH(EVT_W + 2)) u_sync
   (
      .ref_clk  (ref_clk),
      .reset_n  (aux_reset_n),
      .async_in ({event_sources, wake_source, card_clock_pin}),
      .sync_out ({src_sync, wake_src_sync, clk_sync})
   );
   // The wake path runs on the auxiliary reset, so a wake event is still caught while the
   // host holds card reset low in cold sleep.
   // Tracking the clock during reset avoids a false edge when card reset is released.
   always_ff @(posedge ref_clk)
   begin
      if (!reset_n)
      begin
         clk_prev        <= clk_sync;
         card_clock_edge <= 1'b0;
      end
      else
      begin
         clk_prev        <= clk_sync;
         card_clock_edge <= clk_sync & ~clk_prev;
      end
   end
   always_ff @(posedge ref_clk)
   begin
      if (!aux_reset_n)
         wake_src_prev <= 1'b0;
      else
         wake_src_prev <= wake_src_sync; // RL5
   end
   wire wake_event = wake_src_sync & ~wake_src_prev;
   // Wake status survives card reset only on auxiliary power; otherwise both resets clear it.
   wire status_reset = AUX_POWERED ? !aux_reset_n : (!aux_reset_n || !reset_n); // RL19
   // Wake context resets with the auxiliary reset so it is kept across cold sleep while wake enable is set.
   wire ctx_reset = !aux_reset_n;
   // ******************************************************
   // Wake enable
   // ******************************************************
   always_ff @(posedge ref_clk)
   begin
      if (ctx_reset)
         wake_enable <= 1'b0; // RL16
      else if (pm_write.clr_en)
         wake_enable <= 1'b0;
      else if (pm_write.set_en)
         wake_enable <= 1'b1;
      // Mask writes do not touch the enable bit. RL9 RL15
   end
   // ******************************************************
   // Event mask register
   // ******************************************************
   function automatic logic [EVT_W-1:0] wake_bits();
      logic [EVT_W-1:0] m;
      m = '0;
      m[`MASK_GENERAL_WAKEUP_BIT_POS] = 1'b1;
      m[`MASK_WAKEUP_MASK_BIT_POS]  = 1'b1;
      return m;
   endfunction
   logic [EVT_W-1:0] next_mask;
   always_comb
   begin
      next_mask = event_mask;
      if (mask_write)
         next_mask = mask_wdata;
      if (pm_write.clr_en)
         next_mask = next_mask & ~wake_bits(); // RL8 RL12
      else if (pm_write.set_en)
         next_mask = next_mask | wake_bits(); // RL8
   end
   always_ff @(posedge ref_clk)
   begin
      if (ctx_reset)
         event_mask <= `EVT_RESET; // RL16
      else if (!cold_sleep || wake_enable)
         event_mask <= next_mask; // RL5 RL7
      else
         event_mask <= `EVT_RESET;
   end
   // ******************************************************
   // Event register and wake status
   // ******************************************************
   logic [EVT_W-1:0] next_event;
   logic             general_wakeup_bit_cleared;
   always_comb
   begin
      next_event    = event_reg | src_sync;
      general_wakeup_bit_cleared = 1'b0;
      if (event_clear)
      begin
         next_event    = next_event & ~event_clear_bits;
         general_wakeup_bit_cleared = event_clear_bits[`MASK_GENERAL_WAKEUP_BIT_POS];
      end
      if (pm_write.clr_status)
      begin
         next_event[`MASK_GENERAL_WAKEUP_BIT_POS] = 1'b0; // RL13
         general_wakeup_bit_cleared               = 1'b1;
      end
      next_event[`MASK_GENERAL_WAKEUP_BIT_POS] = next_event[`MASK_GENERAL_WAKEUP_BIT_POS] & ~src_sync[`MASK_GENERAL_WAKEUP_BIT_POS];
      if (wake_event && wake_enable)
         next_event[`MASK_GENERAL_WAKEUP_BIT_POS] = 1'b1; // RL10 RL11
      else if (!general_wakeup_bit_cleared)
         next_event[`MASK_GENERAL_WAKEUP_BIT_POS] = event_reg[`MASK_GENERAL_WAKEUP_BIT_POS];
   end
   always_ff @(posedge ref_clk)
   begin
      if (ctx_reset)
         event_reg <= `EVT_RESET; // RL16
      else if (!cold_sleep || wake_enable)
         event_reg <= next_event; // RL5 RL7
      else
         event_reg <= `EVT_RESET;
   end
   always_ff @(posedge ref_clk)
   begin
      if (status_reset)
         wake_status <= 1'b0; // RL16
      else if (wake_event && wake_enable)
         wake_status <= 1'b1; // RL11
      else if (pm_write.clr_status || (general_wakeup_bit_cleared && wake_enable))
         wake_status <= 1'b0; // RL13 RL15
   end
   // ******************************************************
   // Card status change pin
   // ******************************************************
   wire [EVT_W-1:0] masked = event_reg & event_mask;
   wire general_wakeup_bit_path = masked[`MASK_GENERAL_WAKEUP_BIT_POS] & event_mask[`MASK_WAKEUP_MASK_BIT_POS] & wake_status;
   logic [EVT_W-1:0] other_bits;
   always_comb
   begin
      other_bits = masked;
      other_bits[`MASK_GENERAL_WAKEUP_BIT_POS] = 1'b0;
      other_bits[`MASK_WAKEUP_MASK_BIT_POS]  = 1'b0;
   end
   wire raw_change = general_wakeup_bit_path | (|other_bits); // RL14 RL18 RL20
   always_ff @(posedge ref_clk)
   begin
      if (status_reset)
         card_status_change <= 1'b0; // RL16
      else if (power_state == DEV_D0 && !cold_sleep)
         card_status_change <= raw_change; // RL17
      else
         card_status_change <= raw_change & wake_enable & ~pm_write.clr_en; // RL5 RL12 RL17
   end
   // ******************************************************
   // Bus response and interrupt gating
   // ******************************************************
   always_ff @(posedge ref_clk)
   begin
      if (!reset_n)
      begin
         bus_accept <= 1'b0;
         irq_out    <= 1'b0;
      end
      else
      begin
         if (cold_sleep)
            bus_accept <= 1'b0; // RL3
         else if (power_state == DEV_D3)
            bus_accept <= bus_cycle.valid & bus_cycle.type0; // RL1 RL2
         else
            bus_accept <= bus_cycle.valid;
         irq_out <= irq_request & ~cold_sleep & (power_state == DEV_D0); // RL6
      end
   end
   // ******************************************************
   // Checks
   // ******************************************************
   a_cold_no_bus: assert property (@(posedge ref_clk) disable iff (!reset_n)
      cold_sleep |=> !bus_accept) else $error("bus answered in cold sleep"); // RL3
   a_hot_type0_only: assert property (@(posedge ref_clk) disable iff (!reset_n)
      (!cold_sleep && power_state == DEV_D3 && !bus_cycle.type0) |=> !bus_accept)
      else $error("non type 0 cycle answered in D3"); // RL2
   a_cold_no_irq: assert property (@(posedge ref_clk) disable iff (!reset_n)
      cold_sleep |=> !irq_out) else $error("interrupt in cold sleep"); // RL6
   a_en_sets_mask: assert property (@(posedge ref_clk) disable iff (!aux_reset_n)
      (pm_write.set_en && !pm_write.clr_en && (!cold_sleep || wake_enable)) |=>
      event_mask[`MASK_GENERAL_WAKEUP_BIT_POS] && event_mask[`MASK_WAKEUP_MASK_BIT_POS])
      else $error("mask bits not set by enable"); // RL8
   a_en_clr_pin: assert property (@(posedge ref_clk) disable iff (!aux_reset_n)
      (pm_write.clr_en && power_state != DEV_D0) |=> !card_status_change)
      else $error("pin held after enable cleared"); // RL12
   a_mask_keeps_en: assert property (@(posedge ref_clk) disable iff (!aux_reset_n)
      (mask_write && !pm_write.set_en && !pm_write.clr_en) |=> $stable(wake_enable))
      else $error("mask write changed enable"); // RL9
   a_event_sets_st: assert property (@(posedge ref_clk) disable iff (status_reset)
      (wake_event && wake_enable) |=> wake_status)
      else $error("event not latched in status"); // RL11
   a_st_needs_en: assert property (@(posedge ref_clk) disable iff (status_reset)
      (!wake_enable && !$past(wake_enable) && !pm_write.clr_status) |=> $stable(wake_status))
      else $error("status changed with enable low"); // RL15
   a_sleep_gate: assert property (@(posedge ref_clk) disable iff (status_reset)
      (power_state != DEV_D0 && !wake_enable) |=> !card_status_change)
      else $error("pin asserted in sleep without enable"); // RL17
endmodule // card_wake_event_logic

// >>> testbench/host_bridge_model.sv
`timescale 1ns/10ps
module host_bridge_model
(
   input  wire logic host_reset_n,
   input  wire logic cold_sleep,
   input  wire logic card_status_change,
   output logic      card_reset_n,
   output logic      card_clock_pin,
   output logic      wake_request
);
   // *****
   // Card clock and reset
   // *****
   // The clock parks low in cold sleep, so no stale edge can leak into the card.
   initial
   begin
      card_clock_pin = 1'b0;
      #3;
      forever
      begin
         #32;
         card_clock_pin = cold_sleep ? 1'b0 : ~card_clock_pin;
      end
   end
   assign card_reset_n = host_reset_n & ~cold_sleep;
   assign wake_request = card_status_change;
endmodule // host_bridge_model

// >>> testbench/card_wake_event_logic_test.sv
`timescale 1ns/10ps
module card_wake_event_logic_test
   import wake_pkg::*;
;
   logic         ref_clk, host_reset_n, reset_n, aux_reset_n, cold_sleep, clk_pin;
   logic         mask_write, event_clear, wake_source, irq_request, wake_req;
   logic         wake_enable, wake_status, csc, bus_accept, irq_out, clk_edge;
   logic [15:0]  mask_wdata, clr_bits, sources, event_mask, event_reg;
   power_state_t ps;
   pm_write_t    pw;
   bus_cycle_t   bc;
   logic [31:0]  seed;
   int           errors, tests_run, edges;
   card_wake_event_logic #(.EVT_W(16), .AUX_POWERED(1'b1)) i_dut
   (
      .ref_clk(ref_clk), .reset_n(reset_n), .aux_reset_n(aux_reset_n),
      .cold_sleep(cold_sleep), .card_clock_pin(clk_pin), .power_state(ps),
      .pm_write(pw), .mask_write(mask_write), .mask_wdata(mask_wdata),
      .event_clear(event_clear), .event_clear_bits(clr_bits),
      .event_sources(sources), .wake_source(wake_source), .bus_cycle(bc),
      .irq_request(irq_request), .wake_enable(wake_enable), .wake_status(wake_status),
      .event_mask(event_mask), .event_reg(event_reg), .card_status_change(csc),
      .bus_accept(bus_accept), .irq_out(irq_out), .card_clock_edge(clk_edge)
   );
   host_bridge_model i_host
   (
      .host_reset_n(host_reset_n), .cold_sleep(cold_sleep),
      .card_status_change(csc), .card_reset_n(reset_n),
      .card_clock_pin(clk_pin), .wake_request(wake_req)
   );
   // *****
   // Helpers
   // *****
   function automatic logic [31:0] next_rand(logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction
   function automatic logic exp_accept(bus_cycle_t b, power_state_t p, logic c);
      return b.valid & ~c & ((p != DEV_D3) | b.type0);
   endfunction
   task automatic chk1(string name, logic exp, logic got);
      tests_run++;
      if (got !== exp)
      begin
         errors++;
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic chk16(string name, logic [15:0] exp, logic [15:0] got);
      tests_run++;
      if (got !== exp)
      begin
         errors++;
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic give_verdict();
      $display("errors=%0d tests_run=%0d", errors, tests_run);
      if (errors == 0 && tests_run > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // Six cycles cover the longest hand-over latency: three to status, one more to the pin.
   task automatic settle();
      repeat (6) @(posedge ref_clk);
      #1;
   endtask
   task automatic pm(logic [2:0] v);
      @(posedge ref_clk);
      pw <= pm_write_t'(v);
      @(posedge ref_clk);
      pw <= '0;
      settle();
   endtask
   task automatic wr(logic m, logic [15:0] d);
      @(posedge ref_clk);
      mask_write <= m;
      event_clear <= ~m;
      mask_wdata <= d;
      clr_bits <= d;
      @(posedge ref_clk);
      mask_write <= 1'b0;
      event_clear <= 1'b0;
      settle();
   endtask
   task automatic fire();
      @(posedge ref_clk);
      wake_source <= 1'b1;
      repeat (4) @(posedge ref_clk);
      wake_source <= 1'b0;
      settle();
   endtask
   // *****
   // Clock, watchdog and main sequence
   // *****
   initial
   begin
      ref_clk = 1'b0;
      forever #2 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk)
      if (clk_edge === 1'b1)
         edges++;
   initial
   begin
      #100000;
      errors++;
      give_verdict();
   end
   initial
   begin
      {host_reset_n, aux_reset_n, cold_sleep, mask_write, event_clear} = '0;
      {wake_source, irq_request, mask_wdata, clr_bits, sources} = '0;
      ps = DEV_D0;
      {pw, bc} = '0;
      {errors, tests_run, edges} = '0;
      seed = 32'h0000005E;
      repeat (2) @(posedge ref_clk);
      host_reset_n <= 1'b1;
      aux_reset_n <= 1'b1;
      settle();
      chk1("wake_enable", 1'b0, wake_enable);
      chk1("wake_status", 1'b0, wake_status);
      chk1("pin", 1'b0, csc);
      chk16("event_mask", 16'h0000, event_mask);
      chk16("event_reg", 16'h0000, event_reg);
      ps <= DEV_D3;
      pm(3'b100);
      chk16("event_mask", 16'h4010, event_mask);
      fire();
      chk1("wake_status", 1'b1, wake_status);
      chk16("event_reg", 16'h0010, event_reg);
      chk1("pin", 1'b1, csc);
      pm(3'b001);
      chk16("event_reg", 16'h0000, event_reg);
      chk1("pin", 1'b0, csc);
      fire();
      wr(1'b0, 16'h0010);
      chk1("wake_status", 1'b0, wake_status);
      fire();
      pm(3'b010);
      chk1("pin", 1'b0, csc);
      chk16("event_mask", 16'h0000, event_mask);
      fire();
      chk1("pin", 1'b0, csc);
      chk1("wake_status", 1'b1, wake_status);
      pm(3'b001);
      chk1("wake_status", 1'b0, wake_status);
      pm(3'b100);
      wr(1'b1, 16'h000F);
      chk1("wake_enable", 1'b1, wake_enable);
      pm(3'b100);
      fire();
      host_reset_n <= 1'b0;
      repeat (2) @(posedge ref_clk);
      host_reset_n <= 1'b1;
      settle();
      chk1("wake_status", 1'b1, wake_status);
      pm(3'b001);
      cold_sleep <= 1'b1;
      irq_request <= 1'b1;
      bc <= bus_cycle_t'(3'b110);
      repeat (20) @(posedge ref_clk);
      fire();
      edges = 0;
      repeat (40) @(posedge ref_clk);
      #1;
      chk1("clock edges", 1'b0, edges != 0);
      chk16("event_mask", 16'h401F, event_mask);
      chk16("event_reg", 16'h0010, event_reg);
      chk1("pin", 1'b1, csc);
      chk1("wake_request", 1'b1, wake_req);
      chk1("irq_out", 1'b0, irq_out);
      chk1("bus_accept", 1'b0, bus_accept);
      cold_sleep <= 1'b0;
      repeat (40) @(posedge ref_clk);
      #1;
      chk1("clock edges", 1'b1, edges != 0);
      pm(3'b001);
      pm(3'b010);
      for (int i = 0; i < 60; i++)
      begin
         seed = next_rand(seed);
         @(posedge ref_clk);
         bc <= bus_cycle_t'(seed[2:0]);
         ps <= seed[3] ? DEV_D3 : DEV_D0;
         cold_sleep <= seed[4] & seed[5];
         irq_request <= seed[6];
         sources <= seed[31:16];
         @(posedge ref_clk);
         #1;
         chk1("bus_accept", exp_accept(bc, ps, cold_sleep), bus_accept);
         chk1("irq_out", irq_request & (ps == DEV_D0) & ~cold_sleep, irq_out);
         chk1("wake_enable", 1'b0, wake_enable);
      end
      give_verdict();
   end
endmodule // card_wake_event_logic_test
